// *** hdl/rsc_cfg.svh ***
// constants for the reset source controller: offsets, fields, reset values, timing
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
// apb byte offsets
`define RSC_OFS_SYSCTL2     12'h000
`define RSC_OFS_WDCTL1      12'h004
`define RSC_OFS_CAUSE       12'h008
`define RSC_OFS_TRAPCFG     12'h00c
`define RSC_OFS_STATUS      12'h010
`define RSC_OFS_WARMUP      12'h014
// system_control_two fields
`define RSC_SC2_HIGH_OSC    7
`define RSC_SC2_LOW_OSC     6
`define RSC_SC2_MAIN_SEL    5
`define RSC_SC2_RESET       8'hc0
// watchdog_control_one fields
`define RSC_WD_RAM_TRAP     3
`define RSC_WD_TRAP_RESET   2
`define RSC_WD_RESET_OUT    1
`define RSC_WD_ENABLE       0
`define RSC_WD_RESET        8'h07
// reset_cause_flags fields
`define RSC_CF_CLEAR        7
`define RSC_CF_TRIM         5
`define RSC_CF_LVD2         4
`define RSC_CF_LVD1         3
`define RSC_CF_SYSCLK       2
`define RSC_CF_WDOG         1
`define RSC_CF_TRAP         0
// trap area selection
`define RSC_TRAP_SFR_EN     0
`define RSC_TRAP_DBR_EN     1
`define RSC_TRAP_CFG_RESET  8'h03
// address map of the cpu
`define RSC_SFR_LO          16'h0000
`define RSC_SFR_HI          16'h003f
`define RSC_DBR_LO          16'h0f80
`define RSC_DBR_HI          16'h0fff
`define RSC_RAM_LO          16'h0040
`define RSC_RAM_HI          16'h043f
`define RSC_VEC_LO          16'hfffe
`define RSC_VEC_HI          16'hffff
// timing
`define RSC_FC_MHZ          20
`define RSC_PIN_MIN_FC      12
`define RSC_MALF_MAX_FC     24
`define RSC_MALF_CYC        16
`define RSC_WARMUP_US       1000
`define RSC_WARMUP_CYC      (`RSC_WARMUP_US * `RSC_FC_MHZ)
`endif

// *** hdl/rsc_pkg.sv ***
// types for the reset source controller
package rsc_pkg;
  typedef enum logic [2:0] {
    RSC_ST_WARMUP,
    RSC_ST_MALF,
    RSC_ST_PIN,
    RSC_ST_FETCH_LO,
    RSC_ST_FETCH_HI,
    RSC_ST_RUN
  } rsc_state_t;

  typedef enum logic [1:0] {
    RSC_MODE_SINGLE_FAST,
    RSC_MODE_DUAL_FAST,
    RSC_MODE_LOW_ONLY
  } rsc_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rsc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rsc_apb_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } rsc_fetch_t;

  typedef struct packed {
    logic        watchdog;
    logic        lvd1;
    logic        lvd2;
    logic        power_on;
    logic        trim_bad;
  } rsc_src_t;

  typedef struct packed {
    rsc_state_t  st;
    rsc_mode_t   mode;
    logic [14:0] cnt;
    logic [3:0]  pin_cnt;
    logic [7:0]  sc2;
    logic [7:0]  wd;
    logic [7:0]  trap_cfg;
    logic [5:0]  cause;
    logic        trim_latched;
    logic [7:0]  trim;
    logic [7:0]  vec_lo;
    logic [15:0] start_pc;
    logic        int_master_enable;
    logic [23:0] int_individual_enables;
    logic [23:0] int_request_latches;
    logic        trap_int;
    logic [31:0] prdata;
    logic        pslverr;
    logic        sync_wait;
    logic [1:0]  pin_sync;
  } rsc_state_vec_t;
endpackage : rsc_pkg

// *** hdl/rsc_top.sv ***
// reset source controller: merges reset causes into one core reset
// ============================================================
// Function
// R01: malfunction resets hold the core in reset at most 24 fc periods.
// R02: power-on and trim resets hold reset through the warm-up time.
// R03: any reset zeroes master enable, individual enables and request latches.
// R04: reset zeroes prescaler, enables watchdog, disables voltage detection.
// R05: pin low for twelve fc periods applies reset and initialises state.
// R06: after release execution starts at vector read from top two bytes.
// R07: fetch from special, debug or enabled ram area raises address trap.
// R08: trap action is reset or interrupt; trapped areas are selectable.
// R09: clearing both oscillator enables in one write gives clock reset.
// R10: clearing high oscillator enable while high clock selected gives clock reset.
// R11: writing high oscillator enable while low oscillator off gives clock reset.
// R12: clock reset never stops the oscillators.
// R13: software enables high oscillator, waits warm-up, then clears main select.
// R14: after main select cleared, run on low clock until clocks synchronise.
// R15: pin reset ends low-clock-only mode; restart in single-clock fast mode.
// R16: trimming bits are read and latched during power-on warm-up.
// R17: corrupted latched trimming data generates a trimming data reset.
// R18: voltage detector drop generates a voltage detection reset.
// R19: power-on detector generates a power-on reset.
// R20: each internal reset cause sets its own flag, readable after release.
// R21: cause flags clear by writing clear bit or by pin reset.
// R22: pin is synchronised before its low time is counted.
`timescale 1ns/100ps
`include "rsc_cfg.svh"
module rsc_top #(
  parameter int WARMUP_CYC = `RSC_WARMUP_CYC
) (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  // apb slave
  input  wire rsc_pkg::rsc_apb_req_t apb_req,
  output rsc_pkg::rsc_apb_rsp_t     apb_rsp,
  // reset sources
  input  wire logic                 reset_pin_n,
  input  wire rsc_pkg::rsc_src_t    src,
  input  wire rsc_pkg::rsc_fetch_t  fetch,
  // trimming data from flash
  input  wire logic [7:0]           trim_data,
  input  wire logic                 trim_parity,
  // reset vector read
  output logic                      vec_rd,
  output logic                      vec_addr_hi,
  input  wire logic [7:0]           vec_data,
  // clock sync indication
  input  wire logic                 clocks_synced,
  // outputs to the core
  output logic                      core_reset,
  output logic [15:0]               start_pc,
  output logic                      trap_int,
  output logic                      int_master_enable,
  output logic [23:0]               int_individual_enables,
  output logic [23:0]               int_request_latches,
  output logic                      prescaler_clear,
  output logic                      watchdog_enable,
  output logic                      volt_detect_enable,
  output logic                      high_osc_en,
  output logic                      low_osc_en,
  output logic                      main_on_low_clock,
  output rsc_pkg::rsc_mode_t        mode,
  output logic [7:0]                trim_value
);

  rsc_pkg::rsc_state_vec_t q;
  rsc_pkg::rsc_state_vec_t d;

  // ============================================================
  // decode
  logic        acc;
  logic        wr;
  logic        rd;
  logic        pin_low;
  logic        pin_done;
  logic        malf_req;
  logic        clk_fault;
  logic        trap_hit;
  logic [7:0]  wsc2;
  logic        in_sfr;
  logic        in_dbr;
  logic        in_ram;
  logic        known;
  logic [31:0] rdata;

  always_comb begin
    acc      = apb_req.psel && apb_req.penable;
    wr       = acc && apb_req.pwrite;
    rd       = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    pin_low  = !q.pin_sync[1];                                    // [R22]
    pin_done = pin_low && (q.pin_cnt == 4'(`RSC_PIN_MIN_FC - 1)); // [R05]
    wsc2     = apb_req.pwdata[7:0];
    in_sfr   = q.trap_cfg[`RSC_TRAP_SFR_EN] &&
               fetch.addr <= `RSC_SFR_HI;
    in_dbr   = q.trap_cfg[`RSC_TRAP_DBR_EN] &&
               fetch.addr >= `RSC_DBR_LO && fetch.addr <= `RSC_DBR_HI;
    in_ram   = q.wd[`RSC_WD_RAM_TRAP] &&
               fetch.addr >= `RSC_RAM_LO && fetch.addr <= `RSC_RAM_HI;
    trap_hit = q.st == rsc_pkg::RSC_ST_RUN && fetch.valid &&
               (in_sfr || in_dbr || in_ram);                       // [R07]
    clk_fault = 1'b0;
    if (wr && apb_req.paddr == `RSC_OFS_SYSCTL2 && q.st == rsc_pkg::RSC_ST_RUN) begin
      if (!wsc2[`RSC_SC2_HIGH_OSC] && !wsc2[`RSC_SC2_LOW_OSC] &&
          (q.sc2[`RSC_SC2_HIGH_OSC] || q.sc2[`RSC_SC2_LOW_OSC]))
        clk_fault = 1'b1;                                          // [R09]
      if (q.sc2[`RSC_SC2_HIGH_OSC] && !wsc2[`RSC_SC2_HIGH_OSC] &&
          !q.sc2[`RSC_SC2_MAIN_SEL])
        clk_fault = 1'b1;                                          // [R10]
      // setting the high oscillator in a write that leaves the low one off, low clock selected
      if (wsc2[`RSC_SC2_HIGH_OSC] && !q.sc2[`RSC_SC2_HIGH_OSC] &&
          !wsc2[`RSC_SC2_LOW_OSC] && q.sc2[`RSC_SC2_MAIN_SEL])
        clk_fault = 1'b1;                                          // [R11]
    end
    malf_req = q.st == rsc_pkg::RSC_ST_RUN &&
               (clk_fault || src.watchdog || src.lvd1 || src.lvd2 ||
                (trap_hit && q.wd[`RSC_WD_TRAP_RESET]));
    known = 1'b1;
    unique case (apb_req.paddr)
      `RSC_OFS_SYSCTL2: rdata = {24'h0, q.sc2};
      `RSC_OFS_WDCTL1:  rdata = {24'h0, q.wd};
      `RSC_OFS_CAUSE:   rdata = {26'h0, q.cause};                  // [R20]
      `RSC_OFS_TRAPCFG: rdata = {24'h0, q.trap_cfg};
      `RSC_OFS_STATUS:  rdata = {20'h0, q.trim, q.sync_wait, q.trim_latched, q.mode};
      `RSC_OFS_WARMUP:  rdata = 32'(WARMUP_CYC);
      default: begin
        rdata = 32'h0;
        known = 1'b0;
      end
    endcase
  end

  // ============================================================
  // next state
  always_comb begin
    d = q;
    d.pin_sync = {q.pin_sync[0], reset_pin_n};
    d.pin_cnt  = pin_low ? (pin_done ? q.pin_cnt : q.pin_cnt + 4'h1) : 4'h0;
    if (rd) begin
      d.prdata  = rdata;
      d.pslverr = !known;
    end
    if (apb_req.psel && !apb_req.penable && apb_req.pwrite)
      d.pslverr = !known;
    // software writes while running
    if (wr && q.st == rsc_pkg::RSC_ST_RUN) begin
      unique case (apb_req.paddr)
        `RSC_OFS_SYSCTL2: begin
          d.sc2 = wsc2;
          if (q.sc2[`RSC_SC2_MAIN_SEL] && !wsc2[`RSC_SC2_MAIN_SEL])
            d.sync_wait = 1'b1;                                    // [R14]
        end
        `RSC_OFS_WDCTL1:  d.wd = apb_req.pwdata[7:0];
        `RSC_OFS_TRAPCFG: d.trap_cfg = apb_req.pwdata[7:0];        // [R08]
        `RSC_OFS_CAUSE:
          if (apb_req.pwdata[`RSC_CF_CLEAR])
            d.cause = 6'h0;                                        // [R21]
        default: ;
      endcase
    end
    // dual-clock fast is entered only on return from low-only, after synchronisation
    if (q.sync_wait && clocks_synced)
      d.sync_wait = 1'b0;                                          // [R14]
    if (d.sc2[`RSC_SC2_MAIN_SEL])
      d.mode = rsc_pkg::RSC_MODE_LOW_ONLY;
    else if (!d.sync_wait && q.mode == rsc_pkg::RSC_MODE_LOW_ONLY)
      d.mode = d.sc2[`RSC_SC2_LOW_OSC] ? rsc_pkg::RSC_MODE_DUAL_FAST
                                       : rsc_pkg::RSC_MODE_SINGLE_FAST;
    else if (!d.sc2[`RSC_SC2_LOW_OSC])
      d.mode = rsc_pkg::RSC_MODE_SINGLE_FAST;
    // trap as interrupt
    d.trap_int = trap_hit && !q.wd[`RSC_WD_TRAP_RESET];            // [R08]
    if (d.trap_int)
      d.int_request_latches[2] = 1'b1;
    // causes: set wins over a clear-bit write
    if (malf_req) begin
      if (clk_fault)
        d.cause[`RSC_CF_SYSCLK] = 1'b1;                            // [R20]
      if (src.watchdog)
        d.cause[`RSC_CF_WDOG] = 1'b1;
      if (src.lvd1)
        d.cause[`RSC_CF_LVD1] = 1'b1;                              // [R18]
      if (src.lvd2)
        d.cause[`RSC_CF_LVD2] = 1'b1;
      if (trap_hit && q.wd[`RSC_WD_TRAP_RESET])
        d.cause[`RSC_CF_TRAP] = 1'b1;
    end
    unique case (q.st)
      rsc_pkg::RSC_ST_WARMUP: begin                                // [R02]
        if (!q.trim_latched) begin
          d.trim         = trim_data;                              // [R16]
          d.trim_latched = 1'b1;
        end
        if (q.cnt >= 15'(WARMUP_CYC - 1))
          d.st = rsc_pkg::RSC_ST_FETCH_LO;
        else
          d.cnt = q.cnt + 15'h1;
      end
      rsc_pkg::RSC_ST_MALF: begin                                  // [R01]
        if (q.cnt >= 15'(`RSC_MALF_CYC - 1))
          d.st = rsc_pkg::RSC_ST_FETCH_LO;
        else
          d.cnt = q.cnt + 15'h1;
      end
      rsc_pkg::RSC_ST_PIN:
        if (!pin_low)
          d.st = rsc_pkg::RSC_ST_FETCH_LO;                         // [R06]
      rsc_pkg::RSC_ST_FETCH_LO: begin
        d.vec_lo = vec_data;
        d.st     = rsc_pkg::RSC_ST_FETCH_HI;
      end
      rsc_pkg::RSC_ST_FETCH_HI: begin
        d.start_pc = {vec_data, q.vec_lo};                         // [R06]
        d.st       = rsc_pkg::RSC_ST_RUN;
      end
      rsc_pkg::RSC_ST_RUN:
        if (malf_req) begin
          d.st  = rsc_pkg::RSC_ST_MALF;
          d.cnt = 15'h0;
        end
      default:
        d.st = rsc_pkg::RSC_ST_WARMUP;
    endcase
    // state the core sees on any reset entry
    if (d.st != rsc_pkg::RSC_ST_RUN && d.st != rsc_pkg::RSC_ST_FETCH_LO &&
        d.st != rsc_pkg::RSC_ST_FETCH_HI) begin
      d.int_master_enable      = 1'b0;                             // [R03]
      d.int_individual_enables = 24'h0;
      d.int_request_latches    = 24'h0;
      d.wd                     = `RSC_WD_RESET;                    // [R04]
      d.trap_cfg               = `RSC_TRAP_CFG_RESET;
      d.sync_wait              = 1'b0;
      d.mode                   = rsc_pkg::RSC_MODE_SINGLE_FAST;    // [R15]
      // oscillators keep running across a clock reset
      d.sc2 = {q.sc2[7:6] | 2'b10, 6'h0};                          // [R12]
    end
    // pin reset: priority over all but power-on and bad trimming data
    if (pin_done) begin
      d.st    = rsc_pkg::RSC_ST_PIN;                               // [R05]
      d.cause = 6'h0;                                              // [R21]
      d.sc2   = `RSC_SC2_RESET;                                    // [R15]
      d.mode  = rsc_pkg::RSC_MODE_SINGLE_FAST;
      d.int_master_enable      = 1'b0;
      d.int_individual_enables = 24'h0;
      d.int_request_latches    = 24'h0;
    end
    // power-on or bad trimming data restart warm-up
    if (src.power_on || (q.trim_latched && (^q.trim != trim_parity))) begin
      d.st           = rsc_pkg::RSC_ST_WARMUP;                     // [R19]
      d.cnt          = 15'h0;
      d.trim_latched = 1'b0;
      d.sc2          = `RSC_SC2_RESET;
      d.mode         = rsc_pkg::RSC_MODE_SINGLE_FAST;
      if (!src.power_on)
        d.cause[`RSC_CF_TRIM] = 1'b1;                              // [R17]
    end
  end

  // ============================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q                       <= '0;
      q.st                    <= rsc_pkg::RSC_ST_WARMUP;
      q.mode                  <= rsc_pkg::RSC_MODE_SINGLE_FAST;
      q.sc2                   <= `RSC_SC2_RESET;
      q.wd                    <= `RSC_WD_RESET;
      q.trap_cfg              <= `RSC_TRAP_CFG_RESET;
      q.pin_sync              <= 2'b11;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ============================================================
  // outputs
  logic in_reset;
  always_comb begin
    in_reset               = q.st != rsc_pkg::RSC_ST_RUN;
    core_reset             = in_reset;
    start_pc               = q.start_pc;
    trap_int               = q.trap_int;
    int_master_enable      = q.int_master_enable;
    int_individual_enables = q.int_individual_enables;
    int_request_latches    = q.int_request_latches;
    prescaler_clear        = in_reset;                             // [R04]
    watchdog_enable        = q.wd[`RSC_WD_ENABLE];
    volt_detect_enable     = !in_reset;
    high_osc_en            = q.sc2[`RSC_SC2_HIGH_OSC];
    low_osc_en             = q.sc2[`RSC_SC2_LOW_OSC];
    main_on_low_clock      = q.mode == rsc_pkg::RSC_MODE_LOW_ONLY || q.sync_wait;
    mode                   = q.mode;
    trim_value             = q.trim;
    vec_rd                 = q.st == rsc_pkg::RSC_ST_FETCH_LO ||
                             q.st == rsc_pkg::RSC_ST_FETCH_HI;
    vec_addr_hi            = q.st == rsc_pkg::RSC_ST_FETCH_HI;
    apb_rsp.pready         = 1'b1;
    apb_rsp.pslverr        = acc && q.pslverr;
    apb_rsp.prdata         = q.prdata;
  end

endmodule : rsc_top

// *** sim/rsc_chk_sva.sv ***
// assertion checker for the reset source controller
`timescale 1ns/100ps
module rsc_chk (
  // clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // sources
  input wire logic                 clk_en,
  input wire logic                 reset_pin_n,
  input wire rsc_pkg::rsc_src_t    src,
  // vector read
  input wire logic                 vec_rd,
  input wire logic                 vec_addr_hi,
  input wire logic [7:0]           vec_data,
  // core side
  input wire logic                 core_reset,
  input wire logic [15:0]          start_pc,
  input wire logic                 trap_int,
  input wire logic                 int_master_enable,
  input wire logic [23:0]          int_request_latches,
  input wire logic                 prescaler_clear,
  input wire logic                 volt_detect_enable,
  input wire rsc_pkg::rsc_mode_t   mode
);
  logic [4:0] low_q;
  logic       pin_q;
  // counts consecutive low samples of the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q <= 5'h00;
      pin_q <= 1'b0;
    end else begin
      low_q <= reset_pin_n ? 5'h00 : (low_q == 5'h1f ? low_q : low_q + 5'h01);
      pin_q <= (low_q == 5'h12) ? 1'b1 : (core_reset ? pin_q : 1'b0);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence malf_req;
    clk_en && !core_reset && reset_pin_n && !src.power_on && (src.watchdog || src.lvd1 || src.lvd2);
  endsequence
  sequence lo_fetch;
    vec_rd && !vec_addr_hi;
  endsequence
  sequence hi_fetch;
    vec_rd && vec_addr_hi;
  endsequence
  AST_MALF_ENTER: assert property (malf_req |=> core_reset)
    else $error("malfunction reset not entered");
  AST_MALF_BOUND: assert property (malf_req |=> core_reset ##[1:24] !core_reset)
    else $error("malfunction reset too long");
  AST_INT_ZERO: assert property (core_reset && $past(core_reset)
    |-> !int_master_enable && int_request_latches == 24'h000000)
    else $error("interrupt state not cleared");
  AST_INIT_OUT: assert property (core_reset |-> prescaler_clear && !volt_detect_enable)
    else $error("reset initial outputs wrong");
  AST_PIN_APPLY: assert property (low_q == 5'h12 |-> core_reset)
    else $error("pin reset not applied");
  AST_VEC_ORDER: assert property (lo_fetch |=> hi_fetch)
    else $error("vector bytes out of order");
  AST_VEC_PC: assert property (hi_fetch |=> !core_reset && start_pc[15:8] == $past(vec_data))
    else $error("start address not from vector");
  AST_PIN_MODE: assert property (pin_q && $fell(core_reset)
    |-> mode == rsc_pkg::RSC_MODE_SINGLE_FAST)
    else $error("pin reset mode wrong");
  AST_TRAP_PULSE: assert property (trap_int |=> !trap_int)
    else $error("trap interrupt not a pulse");
endmodule : rsc_chk

bind rsc_top rsc_chk chk_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .reset_pin_n(reset_pin_n), .src(src), .vec_rd(vec_rd), .vec_addr_hi(vec_addr_hi),
  .vec_data(vec_data), .core_reset(core_reset), .start_pc(start_pc), .trap_int(trap_int),
  .int_master_enable(int_master_enable), .int_request_latches(int_request_latches),
  .prescaler_clear(prescaler_clear), .volt_detect_enable(volt_detect_enable), .mode(mode));

// *** sim/rsc_mem.sv ***
// vector and trimming memory model facing the controller
`timescale 1ns/100ps
module rsc_mem #(
  parameter logic [15:0] VEC  = 16'h8a31,
  parameter logic [7:0]  TRIM = 8'h5c
) (
  // clock
  input wire logic        pclk,
  // vector read
  input wire logic        vec_rd,
  input wire logic        vec_addr_hi,
  output logic [7:0]      vec_data,
  // trimming flash
  input wire logic        corrupt,
  output logic [7:0]      trim_data,
  output logic            trim_parity
);
  logic [7:0] noise_q = 8'h00;
  always_ff @(posedge pclk) noise_q <= noise_q + 8'h3b;
  // bus shows changing noise when not read
  assign vec_data    = !vec_rd ? noise_q : (vec_addr_hi ? VEC[15:8] : VEC[7:0]);
  assign trim_data   = TRIM;
  assign trim_parity = (^TRIM) ^ corrupt;
endmodule : rsc_mem

// *** sim/reset_source_controller_bench.sv ***
// self-checking bench for the reset source controller
`timescale 1ns/100ps
`include "rsc_cfg.svh"
module reset_source_controller_bench;
  localparam int          WU   = 20;
  localparam logic [15:0] VEC  = 16'h8a31;
  localparam logic [7:0]  TRIM = 8'h5c;
  logic                  pclk = 1'b0, presetn = 1'b0, pin_n = 1'b1, corrupt = 1'b0;
  logic                  synced = 1'b0, vec_rd, vec_hi, core_reset, trap_int, hosc, losc;
  logic                  low_clk, trim_par, err, wd_en;
  logic [7:0]            vec_data, trim_data, trim_v;
  logic [15:0]           start_pc;
  logic [31:0]           rd;
  logic [1:0]            osc;
  rsc_pkg::rsc_apb_req_t req = '0;
  rsc_pkg::rsc_apb_rsp_t rsp;
  rsc_pkg::rsc_src_t     src = '0;
  rsc_pkg::rsc_fetch_t   fetch = '0;
  rsc_pkg::rsc_mode_t    mode;
  int                    failures = 0, n_tests = 0, n;
  int                    cbit [3] = '{`RSC_CF_WDOG, `RSC_CF_LVD1, `RSC_CF_LVD2};
  logic [43:0]           rst_tab [4] = '{{`RSC_OFS_SYSCTL2, 32'hc0}, {`RSC_OFS_WDCTL1, 32'h07},
                           {`RSC_OFS_TRAPCFG, 32'h03}, {`RSC_OFS_STATUS, {20'h0, TRIM, 4'h4}}};
  always #25 pclk = ~pclk;
  rsc_top #(.WARMUP_CYC(WU)) dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .apb_req(req), .apb_rsp(rsp), .reset_pin_n(pin_n), .src(src), .fetch(fetch),
    .trim_data(trim_data), .trim_parity(trim_par), .vec_rd(vec_rd), .vec_addr_hi(vec_hi),
    .vec_data(vec_data), .clocks_synced(synced), .core_reset(core_reset),
    .start_pc(start_pc), .trap_int(trap_int), .int_master_enable(),
    .int_individual_enables(), .int_request_latches(), .prescaler_clear(),
    .watchdog_enable(wd_en), .volt_detect_enable(), .high_osc_en(hosc), .low_osc_en(losc),
    .main_on_low_clock(low_clk), .mode(mode), .trim_value(trim_v));
  rsc_mem #(.VEC(VEC), .TRIM(TRIM)) mem_u (.pclk(pclk), .vec_rd(vec_rd),
    .vec_addr_hi(vec_hi), .vec_data(vec_data), .corrupt(corrupt), .trim_data(trim_data),
    .trim_parity(trim_par));
  // ==========================================================
  // helpers
  task automatic conclude;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic fail_out;
    failures++;
    $display("unexpected at %0t: wait ran out", $time);
    conclude();
  endtask : fail_out
  // waits at falling edges for a level, ends on a rising edge
  task automatic wait_lv(ref logic s, input logic lv, input int lim);
    n = 0;
    do begin
      @(negedge pclk);
      osc = {hosc, losc};
      n++;
      if (n > lim) fail_out();
    end while (s !== lv);
    @(posedge pclk);
  endtask : wait_lv
  // request stands until pready is seen high at a rising edge; the answer is taken there
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
      if (i > 50) fail_out();
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge pclk);
  endtask : apb
  task automatic malf(input logic [31:0] bitno);
    wait_lv(core_reset, 1'b1, 10);
    wait_lv(core_reset, 1'b0, 40);
    chk({31'h0, n <= 24}, 32'h1);
    apb(1'b0, `RSC_OFS_CAUSE, 32'h0);
    chk(rd, 32'h1 << bitno);
  endtask : malf
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wait_lv(core_reset, 1'b0, 200);
    chk({31'h0, n >= WU}, 32'h1);
    chk({16'h0, start_pc}, {16'h0, VEC});
    chk({31'h0, wd_en}, 32'h1);
    chk({24'h0, trim_v}, {24'h0, TRIM});
    foreach (rst_tab[k]) begin
      apb(1'b0, rst_tab[k][43:32], 32'h0);
      chk(rd, rst_tab[k][31:0]);
    end
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int k = 0; k < 3; k++) begin
      src <= rsc_pkg::rsc_src_t'(5'h10 >> k);
      @(posedge pclk);
      src <= '0;
      malf(cbit[k]);
      apb(1'b1, `RSC_OFS_CAUSE, 32'h80);
      apb(1'b0, `RSC_OFS_CAUSE, 32'h0);
      chk(rd, 32'h0);
    end
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `RSC_OFS_SYSCTL2, k ? 32'h40 : 32'h00);
      malf(`RSC_CF_SYSCLK);
      chk({30'h0, osc}, 32'h3);
      apb(1'b1, `RSC_OFS_CAUSE, 32'h80);
    end
    apb(1'b1, `RSC_OFS_SYSCTL2, 32'he0);
    apb(1'b1, `RSC_OFS_SYSCTL2, 32'h60);
    apb(1'b1, `RSC_OFS_SYSCTL2, 32'ha0);
    malf(`RSC_CF_SYSCLK);
    apb(1'b1, `RSC_OFS_CAUSE, 32'h80);
    fetch <= '{valid: 1'b1, addr: 16'h0010};
    @(posedge pclk);
    fetch <= '0;
    malf(`RSC_CF_TRAP);
    apb(1'b1, `RSC_OFS_WDCTL1, 32'h0b);
    fetch <= '{valid: 1'b1, addr: `RSC_RAM_LO};
    @(posedge pclk);
    fetch <= '0;
    wait_lv(trap_int, 1'b1, 8);
    chk({31'h0, core_reset}, 32'h0);
    apb(1'b1, `RSC_OFS_SYSCTL2, 32'he0);
    apb(1'b1, `RSC_OFS_SYSCTL2, 32'hc0);
    repeat (5) @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, low_clk}, 32'h1);
    @(posedge pclk);
    synced <= 1'b1;
    wait_lv(low_clk, 1'b0, 8);
    chk(mode, rsc_pkg::RSC_MODE_DUAL_FAST);
    pin_n <= 1'b0;
    repeat (8) @(posedge pclk);
    pin_n <= 1'b1;
    repeat (20) @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, core_reset}, 32'h0);
    @(posedge pclk);
    pin_n <= 1'b0;
    wait_lv(core_reset, 1'b1, 30);
    chk({31'h0, n >= 12}, 32'h1);
    repeat (5) @(posedge pclk);
    pin_n <= 1'b1;
    wait_lv(core_reset, 1'b0, 40);
    chk(mode, rsc_pkg::RSC_MODE_SINGLE_FAST);
    apb(1'b0, `RSC_OFS_CAUSE, 32'h0);
    chk(rd, 32'h0);
    corrupt <= 1'b1;
    src <= rsc_pkg::rsc_src_t'(5'h02);
    @(posedge pclk);
    src <= '0;
    wait_lv(core_reset, 1'b1, 10);
    repeat (40) @(posedge pclk);
    corrupt <= 1'b0;
    wait_lv(core_reset, 1'b0, 3000);
    apb(1'b0, `RSC_OFS_CAUSE, 32'h0);
    chk(rd & 32'h20, 32'h20);
    conclude();
  end
endmodule : reset_source_controller_bench
